// ---- rtl/watchdog_params.svh ----
// offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

`define WDT_MODE_BANK 4'hf
`define WDT_MODE_ADDR 4'hf
`define WDT_MODE_RESET 8'h0c
`define WDT_TAP_LSB 0
`define WDT_TAP_MSB 1
`define WDT_HALT_BIT 2
`define WDT_STOP_BIT 3
`define WDT_XTAL_BIT 4
`define WDT_SCLK_TO0 20'h00100
`define WDT_SCLK_TO1 20'h00200
`define WDT_SCLK_TO2 20'h00400
`define WDT_SCLK_TO3 20'h01000
`define WDT_CLK_MHZ 10
`define WDT_RC_US0 6250
`define WDT_RC_US1 12500
`define WDT_RC_US2 25000
`define WDT_RC_US3 100000
`define WDT_WINDOW_CYCLES 6'h3c
`define WDT_RESET_HOLD 5'h12
`define WDT_POR_PIN_CYCLES 128
`define WDT_RESET_VECTOR 16'h000c

`endif

// ---- rtl/watchdog_pkg.sv ----
// types shared by the watchdog block
package watchdog_pkg;

  typedef enum logic [0:0] {
    WDT_IDLE = 1'b0,
    WDT_RUN = 1'b1
  } wdt_state_e;

  typedef enum logic [1:0] {
    WIN_WAIT_INSTR = 2'b00,
    WIN_OPEN = 2'b01,
    WIN_CLOSED = 2'b10
  } window_state_e;

  typedef logic [19:0] wdt_count_t;

endpackage

// ---- rtl/reset_stretch.sv ----
// reset stretcher: holds the internal reset a fixed count or while a hold input stands
`timescale 1ns/10ps
`include "watchdog_params.svh"

module reset_stretch (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic hold_i,
  output logic active_o
);

  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic active_reg;
  logic active_next;

  always_comb begin
    count_next = count_reg;
    if (start_i) begin
      count_next = `WDT_RESET_HOLD;
    end else if (count_reg != 5'h00) begin
      count_next = count_reg - 5'h01;
    end
    active_next = start_i | hold_i | (count_next != 5'h00);
  end

  // power-on reset also gets the full hold, hence the nonzero reset value
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= `WDT_RESET_HOLD;
      active_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      active_reg <= active_next;
    end
  end

  assign active_o = active_reg;

endmodule

// ---- rtl/watchdog_with_mode_register.sv ----
// watchdog timer with mode register writable only in a 60-cycle window, and global reset generation
`timescale 1ns/10ps
`include "watchdog_params.svh"

module watchdog_with_mode_register #(
  parameter bit PERMANENT_WDT = 1'b0,
  parameter int RC_CYCLES0 = `WDT_RC_US0 * `WDT_CLK_MHZ,
  parameter int RC_CYCLES1 = `WDT_RC_US1 * `WDT_CLK_MHZ,
  parameter int RC_CYCLES2 = `WDT_RC_US2 * `WDT_CLK_MHZ,
  parameter int RC_CYCLES3 = `WDT_RC_US3 * `WDT_CLK_MHZ
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [3:0] reg_bank_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic instr_exec_i,
  input wire logic wdt_instr_i,
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic stop_recovery_i,
  input wire logic ext_clock_present_i,
  input wire logic low_voltage_i,
  input wire logic reset_pin_in_i,
  output logic [7:0] reg_rdata_o,
  output logic flag_update_o,
  output logic chip_reset_n_o,
  output logic config_keep_o,
  output logic [15:0] reset_vector_o,
  output logic reset_pin_out_o,
  output logic reset_pin_oe_o,
  output logic wdt_running_o
);

  // ****************************************
  // decode and timeout selection
  // ****************************************

  function automatic logic is_mode_reg(input logic [3:0] bank, input logic [3:0] addr);
    is_mode_reg = (bank == `WDT_MODE_BANK) && (addr == `WDT_MODE_ADDR);
  endfunction

  function automatic watchdog_pkg::wdt_count_t timeout_limit(input logic [7:0] mode);
    logic [1:0] tap;
    tap = mode[`WDT_TAP_MSB:`WDT_TAP_LSB];
    timeout_limit = `WDT_SCLK_TO0;
    if (mode[`WDT_XTAL_BIT]) begin
      case (tap)
        2'b00: timeout_limit = `WDT_SCLK_TO0;
        2'b01: timeout_limit = `WDT_SCLK_TO1;
        2'b10: timeout_limit = `WDT_SCLK_TO2;
        default: timeout_limit = `WDT_SCLK_TO3;
      endcase
    end else begin
      // rc timing is approximated on the system clock; the minimums are kept
      case (tap)
        2'b00: timeout_limit = 20'(RC_CYCLES0);
        2'b01: timeout_limit = 20'(RC_CYCLES1);
        2'b10: timeout_limit = 20'(RC_CYCLES2);
        default: timeout_limit = 20'(RC_CYCLES3);
      endcase
    end
  endfunction

  // ****************************************
  // state
  // ****************************************

  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  watchdog_pkg::wdt_state_e wdt_state_reg;
  watchdog_pkg::wdt_state_e wdt_state_next;
  watchdog_pkg::wdt_count_t count_reg;
  watchdog_pkg::wdt_count_t count_next;
  watchdog_pkg::window_state_e win_state_reg;
  watchdog_pkg::window_state_e win_state_next;
  logic [5:0] win_count_reg;
  logic [5:0] win_count_next;
  logic timeout_reg;
  logic timeout_next;
  logic keep_reg;
  logic keep_next;
  logic [7:0] pin_count_reg;
  logic [7:0] pin_count_next;
  logic reset_prev_reg;
  logic flag_reg;
  logic [7:0] rdata_reg;
  logic pin_oe_reg;
  logic pin_oe_next;

  logic reset_active;
  logic ext_hold;
  logic advance;
  logic clock_ok;
  logic enabled;

  // an external reset is only seen while this block is not pulling the pin itself
  assign ext_hold = low_voltage_i | (!reset_pin_in_i & !pin_oe_reg);

  reset_stretch u_stretch (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .start_i(timeout_reg),
    .hold_i(ext_hold),
    .active_o(reset_active)
  );

  // ****************************************
  // watchdog counter
  // ****************************************

  always_comb begin
    enabled = 1'b1;
    if (!PERMANENT_WDT) begin
      if (halt_i && !mode_reg[`WDT_HALT_BIT]) begin
        enabled = 1'b0;
      end
      if (stop_i && !mode_reg[`WDT_STOP_BIT]) begin
        enabled = 1'b0;
      end
    end
    clock_ok = 1'b1;
    if (stop_i && mode_reg[`WDT_XTAL_BIT]) begin
      // crystal halts in stop; only an externally driven clock keeps ticking
      clock_ok = (mode_reg[`WDT_STOP_BIT] | PERMANENT_WDT) & ext_clock_present_i;
    end
    advance = enabled & clock_ok;

    wdt_state_next = wdt_state_reg;
    count_next = count_reg;
    timeout_next = 1'b0;
    keep_next = keep_reg;
    if (reset_active) begin
      wdt_state_next = PERMANENT_WDT ? watchdog_pkg::WDT_RUN : watchdog_pkg::WDT_IDLE;
      count_next = '0;
    end else begin
      keep_next = 1'b0;
      case (wdt_state_reg)
        watchdog_pkg::WDT_IDLE: begin
          if (wdt_instr_i) begin
            wdt_state_next = watchdog_pkg::WDT_RUN;
            count_next = '0;
          end
        end
        watchdog_pkg::WDT_RUN: begin
          if (wdt_instr_i) begin
            count_next = '0;
          end else if (advance) begin
            if (count_reg + 20'h00001 >= timeout_limit(mode_reg)) begin
              timeout_next = 1'b1;
              keep_next = stop_i;
              count_next = '0;
            end else begin
              count_next = count_reg + 20'h00001;
            end
          end
        end
        default: begin
          wdt_state_next = watchdog_pkg::WDT_IDLE;
        end
      endcase
    end
    if (timeout_reg) begin
      keep_next = keep_reg;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_state_reg <= watchdog_pkg::WDT_IDLE;
      count_reg <= '0;
      timeout_reg <= 1'b0;
      keep_reg <= 1'b0;
    end else begin
      wdt_state_reg <= wdt_state_next;
      count_reg <= count_next;
      timeout_reg <= timeout_next;
      keep_reg <= keep_next;
    end
  end

  // ****************************************
  // mode register and write window
  // ****************************************

  always_comb begin
    mode_next = mode_reg;
    win_state_next = win_state_reg;
    win_count_next = win_count_reg;
    if (reset_active) begin
      win_state_next = watchdog_pkg::WIN_WAIT_INSTR;
      win_count_next = 6'h00;
      if (!keep_reg) begin
        mode_next = `WDT_MODE_RESET;
      end
    end else if (stop_recovery_i) begin
      win_state_next = watchdog_pkg::WIN_WAIT_INSTR;
      win_count_next = 6'h00;
    end else begin
      case (win_state_reg)
        watchdog_pkg::WIN_WAIT_INSTR: begin
          if (instr_exec_i) begin
            win_state_next = watchdog_pkg::WIN_OPEN;
          end
        end
        watchdog_pkg::WIN_OPEN: begin
          if (reg_write_i && is_mode_reg(reg_bank_i, reg_addr_i)) begin
            mode_next = {3'b000, reg_wdata_i[4:0]};
          end
          if (win_count_reg == `WDT_WINDOW_CYCLES - 6'h01) begin
            win_state_next = watchdog_pkg::WIN_CLOSED;
          end else begin
            win_count_next = win_count_reg + 6'h01;
          end
        end
        watchdog_pkg::WIN_CLOSED: begin
          win_state_next = watchdog_pkg::WIN_CLOSED;
        end
        default: begin
          win_state_next = watchdog_pkg::WIN_CLOSED;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg <= `WDT_MODE_RESET;
      win_state_reg <= watchdog_pkg::WIN_WAIT_INSTR;
      win_count_reg <= 6'h00;
    end else begin
      mode_reg <= mode_next;
      win_state_reg <= win_state_next;
      win_count_reg <= win_count_next;
    end
  end

  // ****************************************
  // reset pin drive and core outputs
  // ****************************************

  always_comb begin
    pin_count_next = pin_count_reg;
    pin_oe_next = pin_oe_reg;
    if (timeout_reg) begin
      pin_count_next = 8'(`WDT_POR_PIN_CYCLES - 1);
      pin_oe_next = 1'b1;
    end else if (pin_count_reg != 8'h00) begin
      pin_count_next = pin_count_reg - 8'h01;
    end else begin
      pin_oe_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_count_reg <= 8'(`WDT_POR_PIN_CYCLES - 1);
      pin_oe_reg <= 1'b1;
      reset_prev_reg <= 1'b1;
      flag_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      pin_count_reg <= pin_count_next;
      pin_oe_reg <= pin_oe_next;
      reset_prev_reg <= reset_active;
      flag_reg <= wdt_instr_i & !reset_active;
      // write-only register: a read returns no content
      rdata_reg <= reg_read_i ? 8'h00 : rdata_reg;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign flag_update_o = flag_reg;
  assign chip_reset_n_o = !reset_prev_reg;
  assign config_keep_o = keep_reg;
  assign reset_vector_o = `WDT_RESET_VECTOR;
  assign reset_pin_out_o = 1'b0;
  assign reset_pin_oe_o = pin_oe_reg;
  assign wdt_running_o = (wdt_state_reg == watchdog_pkg::WDT_RUN);

endmodule

// ---- testbench/watchdog_with_mode_register_properties.sv ----
// port checker for the watchdog block, bound to its top module
`timescale 1ns/10ps
module watchdog_with_mode_register_properties (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic reg_read_i,
  input wire logic wdt_instr_i,
  input wire logic low_voltage_i,
  input wire logic reset_pin_in_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic flag_update_o,
  input wire logic chip_reset_n_o,
  input wire logic [15:0] reset_vector_o,
  input wire logic reset_pin_out_o,
  input wire logic reset_pin_oe_o,
  input wire logic wdt_running_o
);
  // ****
  // cycle counters
  // ****
  logic [4:0] low_cnt;
  logic [12:0] quiet;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // both saturate so a long stall cannot wrap into a false pass
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt <= 5'h00;
      quiet <= 13'h0000;
    end else begin
      low_cnt <= chip_reset_n_o ? 5'h00 : low_cnt + {4'h0, ~&low_cnt};
      quiet <= wdt_instr_i ? 13'h0000 : quiet + {12'h000, ~&quiet};
    end
  end
  // ****
  // properties
  // ****
  property p_rdata; reg_read_i |=> reg_rdata_o == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data not zero");
  property p_flag; flag_update_o |-> $past(wdt_instr_i); endproperty
  a_flag: assert property (p_flag) else $error("flag without refresh");
  property p_start; wdt_instr_i && chip_reset_n_o |=> flag_update_o && wdt_running_o; endproperty
  a_start: assert property (p_start) else $error("refresh not taken");
  property p_vec; reset_vector_o == 16'h000c; endproperty
  a_vec: assert property (p_vec) else $error("bad start address");
  property p_lowv; low_voltage_i |-> ##[1:3] !chip_reset_n_o; endproperty
  a_lowv: assert property (p_lowv) else $error("low supply without reset");
  property p_hold; $rose(chip_reset_n_o) |-> low_cnt >= 5'h12; endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  property p_early;
    $fell(chip_reset_n_o) |-> quiet >= 13'h0ff || $past(low_voltage_i) || $past(!reset_pin_in_i);
  endproperty
  a_early: assert property (p_early) else $error("early watchdog reset");
  property p_pin; $rose(reset_pin_oe_o) |=> reset_pin_oe_o [*8] ##0 !reset_pin_out_o; endproperty
  a_pin: assert property (p_pin) else $error("reset pin not driven low");
  c_refresh: cover property (wdt_instr_i ##1 flag_update_o);
  c_lowv: cover property (low_voltage_i ##3 !chip_reset_n_o);
  c_timeout: cover property ($fell(chip_reset_n_o) && quiet >= 13'h0ff);
endmodule

bind watchdog_with_mode_register watchdog_with_mode_register_properties checker_i (.clock_i,
  .reset_n_i, .reg_read_i, .wdt_instr_i, .low_voltage_i, .reset_pin_in_i, .reg_rdata_o,
  .flag_update_o,
  .chip_reset_n_o, .reset_vector_o, .reset_pin_out_o, .reset_pin_oe_o, .wdt_running_o);

// ---- testbench/core_model.sv ----
// processor core model: instruction, refresh and mode register strobes
`timescale 1ns/10ps
module core_model (
  input wire logic clock_i,
  output logic reg_write_o,
  output logic reg_read_o,
  output logic [3:0] reg_bank_o,
  output logic [3:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic instr_exec_o,
  output logic wdt_instr_o
);
  // ****
  // strobes
  // ****
  initial begin
    {reg_write_o, reg_read_o, instr_exec_o, wdt_instr_o} = 4'h0;
    {reg_bank_o, reg_addr_o, reg_wdata_o} = 16'h0000;
  end
  // sel 0 write, 1 read, 2 instruction, 3 refresh; one cycle each
  task automatic pulse(input int sel, input logic [7:0] d);
    @(posedge clock_i);
    {reg_bank_o, reg_addr_o, reg_wdata_o} <= {8'hff, d};
    {reg_write_o, reg_read_o, instr_exec_o, wdt_instr_o} <= 4'h8 >> sel;
    @(posedge clock_i);
    {reg_write_o, reg_read_o, instr_exec_o, wdt_instr_o} <= 4'h0;
    // released bus shows inverted data so stale values cannot pass
    {reg_bank_o, reg_addr_o, reg_wdata_o} <= {8'h00, ~d};
  endtask
endmodule

// ---- testbench/tb_watchdog_with_mode_register.sv ----
// self-checking bench for the watchdog block
`timescale 1ns/10ps
module tb_watchdog_with_mode_register;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic halt_i = 1'b0;
  logic stop_i = 1'b0;
  logic ext_clock_present_i = 1'b0;
  logic low_voltage_i = 1'b0;
  logic stop_recovery_i = 1'b0;
  logic reset_pin_in_i = 1'b1;
  logic reg_write_i, reg_read_i, instr_exec_i, wdt_instr_i, flag_update_o, chip_reset_n_o;
  logic config_keep_o, reset_pin_out_o, reset_pin_oe_o, wdt_running_o;
  logic [3:0] reg_bank_i, reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] reset_vector_o;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int lim[4] = '{256, 512, 1024, 4096};
  always #50 clock_i = ~clock_i;
  core_model core (.clock_i, .reg_write_o(reg_write_i), .reg_read_o(reg_read_i),
    .reg_bank_o(reg_bank_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .instr_exec_o(instr_exec_i), .wdt_instr_o(wdt_instr_i));
  // rc timeouts shortened so every tap fits the run
  watchdog_with_mode_register #(.RC_CYCLES0(300), .RC_CYCLES1(600), .RC_CYCLES2(1200),
    .RC_CYCLES3(4800)) dut (.clock_i, .reset_n_i, .reg_write_i, .reg_read_i, .reg_bank_i,
    .reg_addr_i, .reg_wdata_i, .instr_exec_i, .wdt_instr_i, .halt_i, .stop_i,
    .stop_recovery_i, .ext_clock_present_i, .low_voltage_i, .reset_pin_in_i,
    .reg_rdata_o, .flag_update_o, .chip_reset_n_o, .config_keep_o, .reset_vector_o,
    .reset_pin_out_o, .reset_pin_oe_o, .wdt_running_o);
  // ****
  // helpers
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_rst(input int lim_c, output int n);
    n = 0;
    while (chip_reset_n_o === 1'b1 && n < lim_c) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (chip_reset_n_o !== 1'b1 && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    check(n < 300, 1'b1);
  endtask
  task automatic set_mode(input int gap, input logic [7:0] d);
    wait_run();
    core.pulse(2, 8'h00);
    repeat (gap) @(posedge clock_i);
    core.pulse(0, d);
  endtask
  // refresh, then the reset must follow within a few cycles of the tap
  task automatic wdt_to(input int exp);
    int n;
    core.pulse(3, 8'h00);
    #1 check(flag_update_o, 1'b1);
    wait_rst(exp + 10, n);
    check(n >= exp - 1 && n <= exp + 4, 1'b1);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_modes;
    for (int t = 0; t < 4; t++) begin
      set_mode(57, 8'hf0 | t[7:0]);
      core.pulse(1, 8'h00);
      #1 check(reg_rdata_o, 8'h00);
      wdt_to(lim[t]);
    end
    set_mode(57, 8'h01);
    wdt_to(600);
    set_mode(60, 8'h13);
    wdt_to(300);
  endtask
  task automatic t_restart;
    wait_run();
    core.pulse(3, 8'h00);
    repeat (150) @(posedge clock_i);
    wdt_to(300);
  endtask
  // exp 0: the count must stay frozen while the core sleeps
  task automatic t_sus(input int gap, input logic [7:0] d, input logic h, input logic s,
      input logic e, input int exp);
    int n;
    set_mode(gap, d);
    halt_i <= h;
    stop_i <= s;
    ext_clock_present_i <= e;
    core.pulse(3, 8'h00);
    wait_rst(exp == 0 ? 600 : exp + 10, n);
    if (exp == 0) begin
      check(n, 600);
    end else begin
      check(n >= exp - 1 && n <= exp + 4, 1'b1);
      @(posedge clock_i);
      #1 check(config_keep_o, s);
      @(posedge clock_i);
    end
    halt_i <= 1'b0;
    stop_i <= 1'b0;
    ext_clock_present_i <= 1'b0;
    if (exp == 0) begin
      wait_rst(300, n);
      check(n < 300, 1'b1);
    end else if (s) begin
      wait_run();
      wdt_to(exp);
    end
  endtask
  // a late write is refused; stop recovery must re-arm the window for the same write
  task automatic t_recov;
    set_mode(60, 8'h11);
    @(posedge clock_i);
    stop_recovery_i <= 1'b1;
    @(posedge clock_i);
    stop_recovery_i <= 1'b0;
    core.pulse(2, 8'h00);
    core.pulse(0, 8'h11);
    wdt_to(512);
  endtask
  // pin 0: supply comparator, pin 1: external reset pin once the block stops driving it
  task automatic t_lowv(input logic pin);
    wait_run();
    repeat (130) @(posedge clock_i);
    low_voltage_i <= !pin;
    reset_pin_in_i <= !pin;
    repeat (40) @(posedge clock_i);
    check(chip_reset_n_o, 1'b0);
    low_voltage_i <= 1'b0;
    reset_pin_in_i <= 1'b1;
    wait_run();
    check(reset_vector_o, 16'h000c);
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    check(chip_reset_n_o, 1'b0);
    check(reset_pin_oe_o, 1'b1);
    reset_n_i <= 1'b1;
    t_modes();
    t_restart();
    t_sus(57, 8'h10, 1'b1, 1'b0, 1'b0, 0);
    t_sus(57, 8'h10, 1'b0, 1'b1, 1'b0, 0);
    t_sus(57, 8'h18, 1'b0, 1'b1, 1'b0, 0);
    t_sus(60, 8'h00, 1'b1, 1'b0, 1'b0, 300);
    t_sus(60, 8'h00, 1'b0, 1'b1, 1'b0, 300);
    t_sus(57, 8'h18, 1'b0, 1'b1, 1'b1, 256);
    t_recov();
    t_lowv(1'b0);
    t_lowv(1'b1);
    end_sim();
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      check(cycles, 0);
      end_sim();
    end
  end
endmodule
